// *** pct_pkg.sv ***
package pct_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register port
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;

   localparam logic [ADDR_W-1:0] OFS_STAGE_SELECT   = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_STAGE_ON       = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_COEF_INDEX     = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_COEF_VALUE     = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_PRESET         = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_SAT_ON         = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_SAT_LEVEL      = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_RED_WB_RATIO   = 8'h1c;
   localparam logic [ADDR_W-1:0] OFS_BLUE_WB_RATIO  = 8'h20;

   ////////////////////////////////////////////////////////////////////////////
   // Pixel and coefficient formats
   localparam int unsigned PIX_W     = 8;
   localparam int unsigned COEF_W    = 16;
   localparam int unsigned COEF_FRAC = 10;
   localparam int unsigned NUM_COEF  = 12;
   localparam int unsigned NUM_GAIN  = 9;
   localparam int unsigned SAT_W     = 8;
   localparam int unsigned SAT_FRAC  = 4;
   localparam int unsigned IDX_W     = 4;
   localparam int unsigned PRE_W     = 3;

   localparam logic [COEF_W-1:0] COEF_ONE       = 16'h0400;
   localparam logic [COEF_W-1:0] PRESET_STEP    = 16'h0018;
   localparam logic [COEF_W-1:0] WB_STEP        = 16'h0030;
   localparam logic [SAT_W-1:0]  RST_SAT_LEVEL  = 8'h10;
   localparam logic              RST_CORR_ON    = 1'b1;
   localparam logic              RST_SAT_ON     = 1'b0;

   typedef logic [COEF_W-1:0]                 pct_coef_t;
   typedef pct_coef_t [NUM_COEF-1:0]          pct_coef_set_t;

   typedef struct packed {
      logic                      valid;
      logic [2:0][PIX_W-1:0]     ch;
   } pct_beat_t;

   typedef enum logic [0:0] {
      STAGE_CORRECTION  = 1'b0,
      STAGE_LUMA_CHROMA = 1'b1
   } pct_stage_t;

   typedef enum logic [PRE_W-1:0] {
      PRE_GENERAL    = 3'h0,
      PRE_TUNGSTEN   = 3'h1,
      PRE_WARM_FLUOR = 3'h2,
      PRE_COOL_FLUOR = 3'h3,
      PRE_DAYLIGHT   = 3'h4,
      PRE_CLOUDY     = 3'h5,
      PRE_SHADE      = 3'h6,
      PRE_CUSTOM     = 3'h7
   } pct_preset_t;

   localparam pct_preset_t RST_PRESET = PRE_GENERAL;

   // Luma-chroma matrix, Q6.10, offsets in pixel units
   localparam pct_coef_set_t YUV_COEFS = {
      16'h0080, 16'h0080, 16'h0000,
      16'hffad, 16'hfe53, 16'h0200,
      16'h0200, 16'hfead, 16'hff53,
      16'h0075, 16'h0259, 16'h0132
   };

endpackage : pct_pkg

// *** pct_color_transform.sv ***
`timescale 1ns/1ns
module pct_color_transform
   import pct_pkg::*;
(
   input  wire logic                       i_mclk,
   input  wire logic                       i_sys_rst,
   input  wire logic [pct_pkg::ADDR_W-1:0] i_reg_addr,
   input  wire logic [pct_pkg::DATA_W-1:0] i_reg_wdata,
   input  wire logic                       i_reg_wr,
   input  wire logic                       i_reg_rd,
   output logic      [pct_pkg::DATA_W-1:0] o_reg_rdata,
   input  wire logic                       i_image_pipe_on,
   input  wire logic                       i_polarized_variant,
   input  wire logic                       i_yuv_format,
   input  wire pct_pkg::pct_beat_t         i_pix,
   output pct_pkg::pct_beat_t              o_gamma_pix,
   input  wire pct_pkg::pct_beat_t         i_gamma_pix,
   output pct_pkg::pct_beat_t              o_pix,
   output logic      [pct_pkg::COEF_W-1:0] o_red_wb_ratio,
   output logic      [pct_pkg::COEF_W-1:0] o_blue_wb_ratio
);
   import pct_pkg::*;

   localparam logic [PIX_W-1:0] PIX_MAX = '1;

   ////////////////////////////////////////////////////////////////////////////
   // Functions

   // Calibrated matrix for a preset: diagonal entries 0 and 8 trimmed per light source, entry 4 kept at one
   function automatic pct_coef_t preset_coef(input logic [PRE_W-1:0] p, input logic [IDX_W-1:0] i);
      pct_coef_t step;
      step = COEF_W'(PRESET_STEP * COEF_W'(p));
      unique case (i)
         4'h0:    preset_coef = COEF_ONE + step;
         4'h4:    preset_coef = COEF_ONE;
         4'h8:    preset_coef = COEF_ONE - step;
         default: preset_coef = '0;
      endcase
   endfunction : preset_coef

   function automatic pct_coef_set_t preset_set(input logic [PRE_W-1:0] p);
      pct_coef_set_t s;
      s = '0;
      for (int k = 0; k < NUM_COEF; k++)
      begin
         s[k] = preset_coef(p, IDX_W'(k));
      end
      preset_set = s;
   endfunction : preset_set

   function automatic logic [PIX_W-1:0] clamp_pix(input logic signed [31:0] v);
      if (v < 0)
      begin
         clamp_pix = '0;
      end
      else if (v > 32'(PIX_MAX))
      begin
         clamp_pix = PIX_MAX;
      end
      else
      begin
         clamp_pix = v[PIX_W-1:0];
      end
   endfunction : clamp_pix

   // Gains at index row*3+col, offsets at 9..11
   function automatic logic [2:0][PIX_W-1:0] mat_apply(input logic [2:0][PIX_W-1:0] p, input pct_coef_set_t c);
      logic signed [31:0] acc;
      logic signed [31:0] cv;
      logic signed [31:0] pv;
      logic [2:0][PIX_W-1:0] r;
      acc = '0;
      cv  = '0;
      pv  = '0;
      r   = '0;
      for (int row = 0; row < 3; row++)
      begin
         cv  = 32'(signed'(c[NUM_GAIN + row]));
         acc = cv <<< COEF_FRAC;
         for (int col = 0; col < 3; col++)
         begin
            cv  = 32'(signed'(c[row * 3 + col]));
            pv  = 32'(p[col]);
            acc = acc + cv * pv;
         end
         r[row] = clamp_pix(acc >>> COEF_FRAC);
      end
      mat_apply = r;
   endfunction : mat_apply

   ////////////////////////////////////////////////////////////////////////////
   // Configuration state

   pct_stage_t               stage_sel_reg;
   logic                     corr_on_reg;
   logic [IDX_W-1:0]         coef_index_reg;
   pct_preset_t              preset_reg;
   logic                     sat_on_reg;
   logic [SAT_W-1:0]         sat_level_reg;
   logic [COEF_W-1:0]        red_wb_reg;
   logic [COEF_W-1:0]        blue_wb_reg;
   pct_coef_set_t            custom_reg;
   pct_coef_set_t            active_set;
   logic                     reachable;
   logic                     wr_ok;
   logic [DATA_W-1:0]        rdata_next;

   // Controls vanish when the pipe is off or on polarized parts
   assign reachable = i_image_pipe_on & ~i_polarized_variant;
   assign wr_ok     = i_reg_wr & reachable;

   // Matrix in use by the correction stage
   assign active_set = (preset_reg == PRE_CUSTOM) ? custom_reg : preset_set(preset_reg);

   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
      begin
         stage_sel_reg <= STAGE_CORRECTION;
      end
      else if (wr_ok && i_reg_addr == OFS_STAGE_SELECT)
      begin
         stage_sel_reg <= pct_stage_t'(i_reg_wdata[0]);
      end
   end

   // Luma-chroma enable has no storage; writes while it is selected drop
   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
      begin
         corr_on_reg <= RST_CORR_ON;
      end
      else if (wr_ok && i_reg_addr == OFS_STAGE_ON && stage_sel_reg == STAGE_CORRECTION)
      begin
         corr_on_reg <= i_reg_wdata[0];
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
      begin
         coef_index_reg <= '0;
      end
      else if (wr_ok && i_reg_addr == OFS_COEF_INDEX && i_reg_wdata[IDX_W-1:0] < IDX_W'(NUM_COEF))
      begin
         coef_index_reg <= i_reg_wdata[IDX_W-1:0];
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
      begin
         preset_reg <= RST_PRESET;
      end
      else if (wr_ok && i_reg_addr == OFS_PRESET)
      begin
         preset_reg <= pct_preset_t'(i_reg_wdata[PRE_W-1:0]);
      end
   end

   // Custom matrix; identity after reset
   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
      begin
         custom_reg <= preset_set(PRE_GENERAL);
      end
      else if (wr_ok && i_reg_addr == OFS_COEF_VALUE && preset_reg == PRE_CUSTOM
               && stage_sel_reg == STAGE_CORRECTION)
      begin
         custom_reg[coef_index_reg] <= i_reg_wdata[COEF_W-1:0];
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
      begin
         sat_on_reg    <= RST_SAT_ON;
         sat_level_reg <= RST_SAT_LEVEL;
      end
      else if (wr_ok && i_reg_addr == OFS_SAT_ON)
      begin
         sat_on_reg <= i_reg_wdata[0];
      end
      else if (wr_ok && i_reg_addr == OFS_SAT_LEVEL)
      begin
         sat_level_reg <= i_reg_wdata[SAT_W-1:0];
      end
   end

   // Preset loads ratios; direct writes override afterwards
   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
      begin
         red_wb_reg  <= COEF_ONE;
         blue_wb_reg <= COEF_ONE;
      end
      else if (wr_ok && i_reg_addr == OFS_PRESET)
      begin
         red_wb_reg  <= COEF_W'(COEF_ONE + WB_STEP * COEF_W'(i_reg_wdata[PRE_W-1:0]));
         blue_wb_reg <= COEF_W'(COEF_ONE - WB_STEP * COEF_W'(i_reg_wdata[PRE_W-1:0]));
      end
      else if (wr_ok && i_reg_addr == OFS_RED_WB_RATIO)
      begin
         red_wb_reg <= i_reg_wdata[COEF_W-1:0];
      end
      else if (wr_ok && i_reg_addr == OFS_BLUE_WB_RATIO)
      begin
         blue_wb_reg <= i_reg_wdata[COEF_W-1:0];
      end
   end

   assign o_red_wb_ratio  = red_wb_reg;
   assign o_blue_wb_ratio = blue_wb_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Read port

   always_comb
   begin
      rdata_next = '0;
      unique case (i_reg_addr)
         OFS_STAGE_SELECT:  rdata_next[0] = stage_sel_reg;
         OFS_STAGE_ON:      rdata_next[0] = (stage_sel_reg == STAGE_CORRECTION) ? corr_on_reg
                                                                              : i_yuv_format;
         OFS_COEF_INDEX:    rdata_next[IDX_W-1:0] = coef_index_reg;
         OFS_COEF_VALUE:    rdata_next = 32'(signed'((stage_sel_reg == STAGE_CORRECTION)
                                         ? active_set[coef_index_reg]
                                         : YUV_COEFS[coef_index_reg]));
         OFS_PRESET:        rdata_next[PRE_W-1:0] = preset_reg;
         OFS_SAT_ON:        rdata_next[0] = sat_on_reg;
         OFS_SAT_LEVEL:     rdata_next[SAT_W-1:0] = sat_level_reg;
         OFS_RED_WB_RATIO:  rdata_next[COEF_W-1:0] = red_wb_reg;
         OFS_BLUE_WB_RATIO: rdata_next[COEF_W-1:0] = blue_wb_reg;
         default:           rdata_next = '0;
      endcase
      if (!reachable)
      begin
         rdata_next = '0;
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
      begin
         o_reg_rdata <= '0;
      end
      else if (i_reg_rd)
      begin
         o_reg_rdata <= rdata_next;
      end
      else
      begin
         o_reg_rdata <= '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pixel path: correction, saturation, out to gamma, back, luma-chroma

   pct_beat_t               corr_reg;
   logic [2:0][PIX_W-1:0]   sat_ch;

   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
      begin
         corr_reg <= '0;
      end
      else
      begin
         corr_reg.valid <= i_pix.valid;
         corr_reg.ch    <= corr_on_reg ? mat_apply(i_pix.ch, active_set) : i_pix.ch;
      end
   end

   // Each channel pushed away from luma by level/16
   always_comb
   begin
      logic signed [31:0] luma;
      logic signed [31:0] diff;
      luma   = '0;
      diff   = '0;
      sat_ch = corr_reg.ch;
      luma   = (32'(corr_reg.ch[0]) + 32'(corr_reg.ch[1]) * 2 + 32'(corr_reg.ch[2])) >>> 2;
      for (int k = 0; k < 3; k++)
      begin
         diff      = 32'(corr_reg.ch[k]) - luma;
         sat_ch[k] = clamp_pix(luma + ((diff * signed'(32'(sat_level_reg))) >>> SAT_FRAC));
      end
      if (!sat_on_reg)
      begin
         sat_ch = corr_reg.ch;
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
      begin
         o_gamma_pix <= '0;
      end
      else
      begin
         o_gamma_pix.valid <= corr_reg.valid;
         o_gamma_pix.ch    <= sat_ch;
      end
   end

   // Luma-chroma after gamma; runs only in YUV pixel formats
   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
      begin
         o_pix <= '0;
      end
      else
      begin
         o_pix.valid <= i_gamma_pix.valid;
         o_pix.ch    <= i_yuv_format ? mat_apply(i_gamma_pix.ch, YUV_COEFS)
                                     : i_gamma_pix.ch;
      end
   end

endmodule : pct_color_transform

// *** pct_gamma_model.sv ***
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Identity gamma block: returns each beat in the same cycle
module pct_gamma_model
(
   input  wire pct_pkg::pct_beat_t i_pix,
   output pct_pkg::pct_beat_t      o_pix
);
   import pct_pkg::*;
   assign o_pix = i_pix;
endmodule : pct_gamma_model

// *** pct_color_transform_properties.sv ***
`timescale 1ns/1ns
module pct_color_transform_chk
(
   input wire logic                       i_mclk,
   input wire logic                       i_sys_rst,
   input wire logic [pct_pkg::ADDR_W-1:0] i_reg_addr,
   input wire logic [pct_pkg::DATA_W-1:0] i_reg_wdata,
   input wire logic                       i_reg_wr,
   input wire logic                       i_reg_rd,
   input wire logic [pct_pkg::DATA_W-1:0] o_reg_rdata,
   input wire logic                       i_image_pipe_on,
   input wire logic                       i_polarized_variant,
   input wire logic                       i_yuv_format,
   input wire pct_pkg::pct_beat_t         i_pix,
   input wire pct_pkg::pct_beat_t         o_gamma_pix,
   input wire pct_pkg::pct_beat_t         i_gamma_pix,
   input wire pct_pkg::pct_beat_t         o_pix,
   input wire logic [pct_pkg::COEF_W-1:0] o_red_wb_ratio,
   input wire logic [pct_pkg::COEF_W-1:0] o_blue_wb_ratio
);
   import pct_pkg::*;
   logic acc_ok;
   assign acc_ok = i_image_pipe_on && !i_polarized_variant;
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_sys_rst);
   ////////////////////////////////////////////////////////////////////////////
   chk_rdata_idle: assert property (!i_reg_rd |=> o_reg_rdata == '0)
      else $error("read data not zero outside read answer");
   chk_locked_read: assert property (i_reg_rd && !acc_ok |=> o_reg_rdata == '0)
      else $error("read while locked returned data");
   chk_gamma_lat: assert property (i_pix.valid |-> ##2 o_gamma_pix.valid)
      else $error("corrected beat missing two cycles after input");
   chk_gamma_idle: assert property (!i_pix.valid |-> ##2 !o_gamma_pix.valid)
      else $error("spurious corrected beat");
   chk_pix_lat: assert property (i_gamma_pix.valid |=> o_pix.valid)
      else $error("final beat missing after gamma beat");
   chk_yuv_black: assert property (i_yuv_format && i_gamma_pix.valid && i_gamma_pix.ch == '0
      |=> o_pix.ch == 24'h808000)
      else $error("black pixel luma-chroma result wrong");
   chk_rgb_pass: assert property (!i_yuv_format && i_gamma_pix.valid
      |=> o_pix.ch == $past(i_gamma_pix.ch))
      else $error("rgb format pixel altered by luma-chroma stage");
   chk_preset_wb: assert property (i_reg_wr && acc_ok && i_reg_addr == OFS_PRESET
      |=> o_red_wb_ratio == 16'(COEF_ONE + WB_STEP * $past(i_reg_wdata[2:0]))
      && o_blue_wb_ratio == 16'(COEF_ONE - WB_STEP * $past(i_reg_wdata[2:0])))
      else $error("preset did not load white-balance ratios");
   chk_wb_hold: assert property (!(i_reg_wr && acc_ok)
      |=> $stable(o_red_wb_ratio) && $stable(o_blue_wb_ratio))
      else $error("white-balance ratio changed without write");
   cov_preset: cover property (i_reg_wr && acc_ok && i_reg_addr == OFS_PRESET);
   cov_yuv_pix: cover property (i_yuv_format && i_gamma_pix.valid);
   cov_locked: cover property (i_reg_rd && !acc_ok);
endmodule : pct_color_transform_chk

bind pct_color_transform pct_color_transform_chk u_chk (
   .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
   .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_image_pipe_on(i_image_pipe_on),
   .i_polarized_variant(i_polarized_variant), .i_yuv_format(i_yuv_format), .i_pix(i_pix),
   .o_gamma_pix(o_gamma_pix), .i_gamma_pix(i_gamma_pix), .o_pix(o_pix),
   .o_red_wb_ratio(o_red_wb_ratio), .o_blue_wb_ratio(o_blue_wb_ratio)
);

// *** test_pixel_color_transform.sv ***
`timescale 1ns/1ns
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin num_errors++; \
   $display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end
module test_pixel_color_transform;
   import pct_pkg::*;
   logic              i_mclk;
   logic              i_sys_rst;
   logic [ADDR_W-1:0] i_reg_addr;
   logic [DATA_W-1:0] i_reg_wdata;
   logic              i_reg_wr;
   logic              i_reg_rd;
   logic [DATA_W-1:0] o_reg_rdata;
   logic              i_image_pipe_on;
   logic              i_polarized_variant;
   logic              i_yuv_format;
   pct_beat_t         i_pix;
   pct_beat_t         o_gamma_pix;
   pct_beat_t         i_gamma_pix;
   pct_beat_t         o_pix;
   logic [COEF_W-1:0] o_red_wb_ratio;
   logic [COEF_W-1:0] o_blue_wb_ratio;
   int                checks = 0;
   int                num_errors = 0;
   int                cycles = 0;

   pct_color_transform DUT (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_reg_addr(i_reg_addr),
      .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
      .i_image_pipe_on(i_image_pipe_on), .i_polarized_variant(i_polarized_variant),
      .i_yuv_format(i_yuv_format), .i_pix(i_pix), .o_gamma_pix(o_gamma_pix), .i_gamma_pix(i_gamma_pix),
      .o_pix(o_pix), .o_red_wb_ratio(o_red_wb_ratio), .o_blue_wb_ratio(o_blue_wb_ratio));
   pct_gamma_model u_gamma (.i_pix(o_gamma_pix), .o_pix(i_gamma_pix));

   ////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge i_mclk);
      i_reg_wr    <= 1'b1;
      i_reg_addr  <= a;
      i_reg_wdata <= d;
      @(posedge i_mclk);
      i_reg_wr <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      @(posedge i_mclk);
      i_reg_rd   <= 1'b1;
      i_reg_addr <= a;
      @(posedge i_mclk);
      i_reg_rd <= 1'b0;
      #1;
      `CHK(o_reg_rdata, e)
   endtask : rd
   // Channels packed {B, G, R} or {Cr, Cb, Y}
   task automatic px(input logic [23:0] c, input logic [23:0] eg, input logic [23:0] eo);
      @(posedge i_mclk);
      i_pix <= {1'b1, c};
      @(posedge i_mclk);
      i_pix <= {1'b0, ~c};
      @(posedge i_mclk);
      #1;
      `CHK({o_gamma_pix.valid, o_gamma_pix.ch}, {1'b1, eg})
      @(posedge i_mclk);
      #1;
      `CHK({o_pix.valid, o_pix.ch}, {1'b1, eo})
   endtask : px
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_defaults();
      rd(OFS_STAGE_SELECT, 32'h0);
      rd(OFS_STAGE_ON, 32'h1);
      rd(OFS_PRESET, 32'h0);
      rd(OFS_SAT_LEVEL, 32'h10);
      rd(OFS_COEF_VALUE, 32'h400);
      rd(OFS_RED_WB_RATIO, 32'h400);
      $display("test defaults done");
   endtask : t_defaults
   task automatic t_sat();
      px(24'h323264, 24'h323264, 24'h323264);
      wr(OFS_SAT_LEVEL, 32'h20);
      wr(OFS_SAT_ON, 32'h1);
      px(24'h323264, 24'h26268a, 24'h26268a);
      wr(OFS_SAT_ON, 32'h0);
      $display("test saturation done");
   endtask : t_sat
   task automatic t_preset();
      wr(OFS_PRESET, 32'h3);
      `CHK({o_red_wb_ratio, o_blue_wb_ratio}, 32'h04900370)
      px(24'h646464, 24'h5c646b, 24'h5c646b);
      rd(OFS_COEF_VALUE, 32'h448);
      wr(OFS_STAGE_ON, 32'h0);
      px(24'h646464, 24'h646464, 24'h646464);
      wr(OFS_STAGE_ON, 32'h1);
      $display("test preset done");
   endtask : t_preset
   task automatic t_custom();
      wr(OFS_COEF_INDEX, 32'h9);
      wr(OFS_COEF_VALUE, 32'hc8);
      rd(OFS_COEF_VALUE, 32'h0);
      wr(OFS_PRESET, 32'h7);
      rd(OFS_COEF_VALUE, 32'h0);
      wr(OFS_COEF_VALUE, 32'hc8);
      rd(OFS_COEF_VALUE, 32'hc8);
      wr(OFS_COEF_INDEX, 32'hb);
      wr(OFS_COEF_VALUE, 32'hffce);
      rd(OFS_COEF_VALUE, 32'hffffffce);
      wr(OFS_COEF_INDEX, 32'hc);
      rd(OFS_COEF_INDEX, 32'hb);
      px(24'h146464, 24'h0064ff, 24'h0064ff);
      wr(OFS_RED_WB_RATIO, 32'h123);
      `CHK(o_red_wb_ratio, 16'h0123)
      $display("test custom done");
   endtask : t_custom
   task automatic t_luma();
      wr(OFS_PRESET, 32'h0);
      wr(OFS_STAGE_SELECT, 32'h1);
      rd(OFS_STAGE_ON, 32'h0);
      @(posedge i_mclk);
      i_yuv_format <= 1'b1;
      rd(OFS_STAGE_ON, 32'h1);
      wr(OFS_STAGE_ON, 32'h0);
      wr(OFS_COEF_INDEX, 32'h0);
      rd(OFS_COEF_VALUE, 32'h132);
      wr(OFS_COEF_INDEX, 32'ha);
      rd(OFS_COEF_VALUE, 32'h80);
      px(24'h000000, 24'h000000, 24'h808000);
      px(24'h646464, 24'h646464, 24'h808064);
      @(posedge i_mclk);
      i_yuv_format <= 1'b0;
      wr(OFS_STAGE_SELECT, 32'h0);
      rd(OFS_STAGE_ON, 32'h1);
      $display("test luma-chroma done");
   endtask : t_luma
   task automatic t_locked();
      @(posedge i_mclk);
      i_image_pipe_on <= 1'b0;
      wr(OFS_PRESET, 32'h5);
      `CHK(o_red_wb_ratio, 16'h0400)
      rd(OFS_SAT_LEVEL, 32'h0);
      @(posedge i_mclk);
      i_image_pipe_on     <= 1'b1;
      i_polarized_variant <= 1'b1;
      wr(OFS_PRESET, 32'h5);
      @(posedge i_mclk);
      i_polarized_variant <= 1'b0;
      rd(OFS_PRESET, 32'h0);
      rd(8'h40, 32'h0);
      $display("test locked done");
   endtask : t_locked
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end
   always @(posedge i_mclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 3000)
      begin
         num_errors++;
         give_verdict();
      end
   end
   initial
   begin
      i_sys_rst           = 1'b1;
      i_reg_addr          = '0;
      i_reg_wdata         = '0;
      i_reg_wr            = 1'b0;
      i_reg_rd            = 1'b0;
      i_image_pipe_on     = 1'b1;
      i_polarized_variant = 1'b0;
      i_yuv_format        = 1'b0;
      i_pix               = '0;
      repeat (6) @(posedge i_mclk);
      i_sys_rst <= 1'b0;
      t_defaults();
      t_sat();
      t_preset();
      t_custom();
      t_luma();
      t_locked();
      give_verdict();
   end
endmodule : test_pixel_color_transform
